/* File: pkg/wsc_params.svh */
// constants of the wakeup system controller: register indices,
// field positions, reset values and timing figures
// assumes a 32-bit classic wishbone bus, byte address = 4 * index
`ifndef WSC_PARAMS_SVH
`define WSC_PARAMS_SVH

// register indices; byte address is four times the index
`define WSC_IDX_PERIOD 8'hbc
`define WSC_IDX_FLAGS 8'hc0
`define WSC_IDX_MASK 8'hc1
`define WSC_IDX_STATUS 8'hd9
`define WSC_IDX_CTRL 8'he0

// reset values
`define WSC_FLAGS_RST 8'h00
`define WSC_MASK_RST 8'hff
`define WSC_PERIOD_RST 8'h01

// flag and mask bit positions
`define WSC_BIT_WATCHDOG 7
`define WSC_BIT_TEMP_REL 6
`define WSC_BIT_LF_CARRIER 5
`define WSC_BIT_LF_SYNC 4
`define WSC_BIT_LF_PAT1 3
`define WSC_BIT_LF_PAT0 2
`define WSC_BIT_EXT 1
`define WSC_BIT_INTERVAL 0
// sources that cannot be masked in normal and debug modes
`define WSC_ALWAYS_ON 8'hc1

// status field positions
`define WSC_ST_TEMP 6
`define WSC_ST_MODE_HI 5
`define WSC_ST_MODE_LO 4
`define WSC_ST_PEND 1

// control command bits
`define WSC_CMD_PDOWN 0
`define WSC_CMD_IDLE 1
`define WSC_CMD_TSHUT 2

// execution addresses after reset or wakeup
`define WSC_BOOT_ADDR 16'h0000
`define WSC_FLASH_ADDR 16'h4000

// timing: system clock and low-power oscillator rates in hz
`define WSC_CLK_HZ 40000000
`define WSC_LP_HZ 2000
`define WSC_LP_DIV (`WSC_CLK_HZ / `WSC_LP_HZ)

`endif

/* File: pkg/wsc_pkg.sv */
// types of the wakeup system controller
// assumes nothing of its surroundings
package wsc_pkg;

  // controller states, one-hot
  typedef enum logic [3:0] {
    WSC_RUN = 4'b0001,
    WSC_IDLE = 4'b0010,
    WSC_PDOWN = 4'b0100,
    WSC_TSHUT = 4'b1000
  } wsc_state_t;

  // wakeup sources outside the controller
  typedef struct packed {
    logic watchdog_source;
    logic lf_carrier_source;
    logic lf_sync_source;
    logic lf_pattern1_source;
    logic lf_pattern0_source;
    logic external_wake_pin;
  } wsc_src_t;

endpackage

/* File: logic/wsc_top.sv */
// wakeup system controller: reset/wakeup sequencing, wakeup flags,
// mask, interval timer and diagnosis status behind classic wishbone
// assumes all inputs synchronous to clk_i; the low-power oscillator
// is modelled as a tick divided down from clk_i
//
// Operation
// - controller owns chip outside run state
// - controller steps on the low-power tick
// - system reset clears all, boot then flash
// - wakeup resets cpu only, boot then flash
// - qualified wakeup event returns to run
// - each source gated by its mask bit
// - watchdog, temp release, timer always on in normal/debug
// - reading wakeup flags clears them all
// - new activity sets flag and pending bit
// - disabled source flags always read zero
// - power down keeps wakeup flags
// - only activity after power down wakes
// - watchdog elapse raises watchdog wakeup
// - temp release wakeup only in thermal shutdown
// - lf wakeups gated by mask bits 5..2
// - configured external pin event wakes device
// - timer expiry wakes and sets flag bit 0
// - timer reloads from period and restarts
// - timer keeps counting in run state
// - flag bit layout, reset value zero
// - status bits 5:4 show operating mode
// - status bit 6 shows temperature below limit
// - status bit 1 shows flags changed since read
// - mask 0 enables, 1 disables, resets ff
`include "wsc_params.svh"
`timescale 1ns/1ps

module wsc_top #(
  parameter int LP_DIV = `WSC_LP_DIV // clk_i cycles per lp tick
) (
  input wire logic clk_i, // 40 mhz system clock
  input wire logic rst_i, // synchronous system reset, high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [9:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte selects
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire wsc_pkg::wsc_src_t wake_src_i, // external sources
  input wire logic ext_wake_cfg_i, // pin configured for wakeup
  input wire logic temp_below_limit_i, // temperature below limit
  input wire logic [1:0] operating_mode_field_i, // mode straps
  output logic cpu_run_o, // cpu owns the chip
  output logic ctl_owns_o, // controller owns the chip
  output logic cpu_wake_reset_o, // pulse: reset pc and peripherals
  output logic sys_reset_o, // whole digital circuit in reset
  output logic [15:0] boot_addr_o, // first fetch address
  output logic [15:0] flash_addr_o, // application entry address
  output logic [7:0] wake_event_o // qualified events of last tick
);

  // low-power tick divider
  logic [15:0] div_reg; // divider count
  logic lp_tick; // one cycle per lp oscillator period

  // bus signals
  logic [7:0] bus_idx; // word index of the access
  logic bus_req; // new access this cycle
  logic bus_wr; // write accepted this cycle
  logic bus_rd_flags; // read of the flag register
  logic [7:0] rd_data; // selected read data

  // software registers
  logic [7:0] mask_reg; // wakeup_mask, 1 disables
  logic [7:0] period_reg; // interval_period reload value
  logic [2:0] cmd_reg; // pending state commands
  logic [7:0] flags_reg; // wakeup_flags store
  logic pend_reg; // wake_pending status
  logic [7:0] post_reg; // interval postcounter

  // activity capture
  wsc_pkg::wsc_src_t src_prev_reg; // last sample of sources
  logic temp_prev_reg; // last sample of temperature
  logic [7:0] act_reg; // activity seen since last tick
  logic [7:0] act_new; // activity edges this cycle
  logic [7:0] evt; // events presented at the tick
  logic [7:0] en; // effective source enables
  logic [7:0] qual; // qualified events at the tick
  logic timer_expire; // postcounter expiry at the tick

  // controller state
  wsc_pkg::wsc_state_t state_reg; // current state
  wsc_pkg::wsc_state_t state_next; // next state
  logic wake; // leave a low-power state

  // divider producing the lp tick from clk_i
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg <= 16'h0000;
    end else if (lp_tick) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end

  // tick marks one lp oscillator period
  assign lp_tick = (div_reg == 16'(LP_DIV - 1));

  // bus decode: index from the byte address
  assign bus_idx = wb_adr_i[9:2];
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
  assign bus_rd_flags = bus_req && !wb_we_i &&
    (bus_idx == `WSC_IDX_FLAGS);

  // enables: mask bit 0 enables, forced on in normal/debug
  always_comb begin
    en = ~mask_reg;
    if (operating_mode_field_i[0]) begin
      en = en | `WSC_ALWAYS_ON;
    end
  end

  // read multiplexer, unmapped words read zero
  always_comb begin
    rd_data = 8'h00;
    if (bus_idx == `WSC_IDX_FLAGS) begin
      rd_data = flags_reg & en;
    end else if (bus_idx == `WSC_IDX_MASK) begin
      rd_data = mask_reg;
    end else if (bus_idx == `WSC_IDX_PERIOD) begin
      rd_data = post_reg;
    end else if (bus_idx == `WSC_IDX_STATUS) begin
      rd_data[`WSC_ST_TEMP] = temp_below_limit_i;
      rd_data[`WSC_ST_MODE_HI] = operating_mode_field_i[1];
      rd_data[`WSC_ST_MODE_LO] = operating_mode_field_i[0];
      rd_data[`WSC_ST_PEND] = pend_reg;
    end else if (bus_idx == `WSC_IDX_CTRL) begin
      rd_data = {5'h00, cmd_reg};
    end else begin
      rd_data = 8'h00;
    end
  end

  // wishbone answer: ack one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= {24'h000000, rd_data};
      end
    end
  end

  // mask register, every source disabled after reset except those forced on in normal/debug
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_reg <= `WSC_MASK_RST;
    end else if (bus_wr && bus_idx == `WSC_IDX_MASK) begin
      mask_reg <= wb_dat_i[7:0];
    end
  end

  // period register, new value used at the next reload
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_reg <= `WSC_PERIOD_RST;
    end else if (bus_wr && bus_idx == `WSC_IDX_PERIOD) begin
      period_reg <= wb_dat_i[7:0];
    end
  end

  // state commands: written by software, consumed at the tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_reg <= 3'h0;
    end else if (bus_wr && bus_idx == `WSC_IDX_CTRL) begin
      cmd_reg <= cmd_reg | wb_dat_i[2:0];
    end else if (lp_tick) begin
      cmd_reg <= 3'h0;
    end
  end

  // interval postcounter: counts lp ticks in every state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      post_reg <= `WSC_PERIOD_RST;
    end else if (lp_tick) begin
      if (timer_expire) begin
        post_reg <= period_reg;
      end else begin
        post_reg <= post_reg - 8'h01;
      end
    end
  end

  // value 1 is the last count; 00 stands for 256 ticks
  assign timer_expire = lp_tick && (post_reg == 8'h01);

  // activity edges of the external sources and temperature
  always_comb begin
    act_new = 8'h00;
    act_new[`WSC_BIT_WATCHDOG] = wake_src_i.watchdog_source &&
      !src_prev_reg.watchdog_source;
    act_new[`WSC_BIT_TEMP_REL] = temp_below_limit_i && !temp_prev_reg;
    act_new[`WSC_BIT_LF_CARRIER] = wake_src_i.lf_carrier_source &&
      !src_prev_reg.lf_carrier_source;
    act_new[`WSC_BIT_LF_SYNC] = wake_src_i.lf_sync_source &&
      !src_prev_reg.lf_sync_source;
    act_new[`WSC_BIT_LF_PAT1] = wake_src_i.lf_pattern1_source &&
      !src_prev_reg.lf_pattern1_source;
    act_new[`WSC_BIT_LF_PAT0] = wake_src_i.lf_pattern0_source &&
      !src_prev_reg.lf_pattern0_source;
    act_new[`WSC_BIT_EXT] = wake_src_i.external_wake_pin &&
      !src_prev_reg.external_wake_pin && ext_wake_cfg_i;
  end

  // sample sources for edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // take the present level in reset: a source or temperature that
      // is already high at release must not look like a new edge
      src_prev_reg <= wake_src_i;
      temp_prev_reg <= temp_below_limit_i;
    end else begin
      src_prev_reg <= wake_src_i;
      temp_prev_reg <= temp_below_limit_i;
    end
  end

  // activity held until the next tick so short pulses are kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_reg <= 8'h00;
    end else if (lp_tick) begin
      // an edge in the tick cycle is already in evt; keeping it would
      // present it again at the next tick and wake a fresh power down
      act_reg <= 8'h00;
    end else begin
      act_reg <= act_reg | act_new;
    end
  end

  // events at the tick; temperature release counts only in shutdown
  always_comb begin
    evt = act_reg | act_new;
    evt[`WSC_BIT_TEMP_REL] = evt[`WSC_BIT_TEMP_REL] &&
      (state_reg == wsc_pkg::WSC_TSHUT);
    evt[`WSC_BIT_INTERVAL] = timer_expire;
    qual = evt & en;
  end

  // wakeup flags: set at the tick, cleared by a read, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_reg <= `WSC_FLAGS_RST;
    end else if (bus_rd_flags) begin
      flags_reg <= lp_tick ? qual : 8'h00;
    end else if (lp_tick) begin
      flags_reg <= flags_reg | qual;
    end
  end

  // pending bit: set on new flag activity, cleared by flag read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_reg <= 1'b0;
    end else if (lp_tick && (qual != 8'h00)) begin
      pend_reg <= 1'b1;
    end else if (bus_rd_flags) begin
      pend_reg <= 1'b0;
    end
  end

  // only events of this tick wake, never stored flags
  assign wake = lp_tick && (qual != 8'h00);

  // next state of the controller, stepping on the tick
  always_comb begin
    state_next = state_reg;
    if (lp_tick) begin
      case (state_reg)
        wsc_pkg::WSC_RUN: begin
          if (cmd_reg[`WSC_CMD_TSHUT]) begin
            state_next = wsc_pkg::WSC_TSHUT;
          end else if (cmd_reg[`WSC_CMD_PDOWN]) begin
            state_next = wsc_pkg::WSC_PDOWN;
          end else if (cmd_reg[`WSC_CMD_IDLE]) begin
            state_next = wsc_pkg::WSC_IDLE;
          end
        end
        wsc_pkg::WSC_IDLE: begin
          if (wake) begin
            state_next = wsc_pkg::WSC_RUN;
          end
        end
        wsc_pkg::WSC_PDOWN: begin
          if (wake) begin
            state_next = wsc_pkg::WSC_RUN;
          end
        end
        wsc_pkg::WSC_TSHUT: begin
          if (qual[`WSC_BIT_TEMP_REL] || wake) begin
            state_next = wsc_pkg::WSC_RUN;
          end
        end
        default: begin
          state_next = wsc_pkg::WSC_RUN;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= wsc_pkg::WSC_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // ownership outputs follow the next state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_run_o <= 1'b0;
      ctl_owns_o <= 1'b1;
    end else begin
      cpu_run_o <= (state_next == wsc_pkg::WSC_RUN);
      ctl_owns_o <= (state_next != wsc_pkg::WSC_RUN);
    end
  end

  // wake reset pulse: pc and peripherals only, flags untouched
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_wake_reset_o <= 1'b0;
    end else begin
      cpu_wake_reset_o <= (state_reg != wsc_pkg::WSC_RUN) &&
        (state_next == wsc_pkg::WSC_RUN);
    end
  end

  // system reset output mirrors the reset of the whole circuit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_reset_o <= 1'b1;
    end else begin
      sys_reset_o <= 1'b0;
    end
  end

  // execution addresses for both reset and wakeup start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_addr_o <= `WSC_BOOT_ADDR;
      flash_addr_o <= `WSC_FLASH_ADDR;
    end else begin
      boot_addr_o <= `WSC_BOOT_ADDR;
      flash_addr_o <= `WSC_FLASH_ADDR;
    end
  end

  // qualified events of the most recent tick for observers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_event_o <= 8'h00;
    end else if (lp_tick) begin
      wake_event_o <= qual;
    end
  end

endmodule

/* File: verification/wsc_props.sv */
// checker on the wakeup controller ports
// assumes it is bound into wsc_top
`timescale 1ns/1ps
module wsc_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic cpu_run_o,
  input wire logic ctl_owns_o,
  input wire logic cpu_wake_reset_o,
  input wire logic sys_reset_o,
  input wire logic [15:0] boot_addr_o,
  input wire logic [15:0] flash_addr_o,
  input wire logic [7:0] wake_event_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // request taken, then a one-cycle ack
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
  property p_ack; s_req |=> s_ack; endproperty
  property p_own; ctl_owns_o == !cpu_run_o; endproperty
  property p_adr;
    boot_addr_o == 16'h0000 && flash_addr_o == 16'h4000;
  endproperty
  property p_srst; sys_reset_o |-> $past(rst_i); endproperty
  // a wake reset is one cycle long and lands in run
  property p_puls;
    cpu_wake_reset_o |-> cpu_run_o ##1 !cpu_wake_reset_o;
  endproperty
  property p_wake;
    $rose(cpu_run_o) && !$past(sys_reset_o) |-> cpu_wake_reset_o;
  endproperty
  property p_why; cpu_wake_reset_o |-> wake_event_o != 8'h00; endproperty
  property p_trel; $rose(wake_event_o[6]) |-> $past(ctl_owns_o); endproperty
  a_ack: assert property (p_ack) else $error("bus ack wrong");
  a_own: assert property (p_own) else $error("owner wrong");
  a_adr: assert property (p_adr) else $error("entry wrong");
  a_srst: assert property (p_srst) else $error("sys reset wrong");
  a_puls: assert property (p_puls) else $error("wake pulse wrong");
  a_wake: assert property (p_wake) else $error("no wake reset");
  a_why: assert property (p_why) else $error("wake without event");
  a_trel: assert property (p_trel) else $error("release in run");
endmodule
bind wsc_top wsc_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .cpu_run_o, .ctl_owns_o, .cpu_wake_reset_o, .sys_reset_o,
  .boot_addr_o, .flash_addr_o, .wake_event_o);

/* File: verification/wsc_src_model.sv */
// far side model: wakeup sources feeding the controller
// assumes kick_i is a one-cycle request from the bench
`timescale 1ns/1ps
module wsc_src_model (
  input wire logic clk_i,
  input wire logic slow_i, // answer one cycle late
  input wire logic [5:0] kick_i, // sources to pulse
  output wsc_pkg::wsc_src_t src_o // rising edge is activity
);
  logic [5:0] late_reg; // delayed copy for slow answers
  // each kick becomes one rising edge, then the line drops
  always_ff @(posedge clk_i) begin
    late_reg <= kick_i;
  end
  assign src_o = wsc_pkg::wsc_src_t'(slow_i ? late_reg : kick_i);
endmodule

/* File: verification/wsc_top_tb.sv */
// bench for the wakeup controller: registers, masks, sleep, wake
// assumes wsc_top with a short tick and the source model
`timescale 1ns/1ps
module wsc_top_tb;
  localparam int DIV = 8; // clk cycles per tick in sim
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc = 1'h0, we = 1'h0, slow = 1'h0, temp = 1'h1, cfg = 1'h1;
  logic [9:0] adr = 10'h000;
  logic [31:0] wdat = 32'h0, rdat;
  logic [1:0] mode = 2'h0;
  logic [5:0] kick = 6'h00;
  logic [7:0] q;
  logic ack, run;
  wsc_pkg::wsc_src_t src;
  int fail_count = 0, check_count = 0, cyc_n = 0;
  always #12.5 clk_i = ~clk_i;
  wsc_src_model u_src (.clk_i, .slow_i(slow), .kick_i(kick), .src_o(src));
  wsc_top #(.LP_DIV(DIV)) dut (.clk_i, .rst_i, .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wake_src_i(src),
    .ext_wake_cfg_i(cfg), .temp_below_limit_i(temp),
    .operating_mode_field_i(mode), .cpu_run_o(run), .ctl_owns_o(),
    .cpu_wake_reset_o(), .sys_reset_o(), .boot_addr_o(),
    .flash_addr_o(), .wake_event_o());
  task automatic check(input logic [7:0] seen, exp, input string what);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] idx, d);
    @(posedge clk_i);
    cyc <= 1'h1;
    we <= w;
    adr <= {idx, 2'h0};
    wdat <= {24'h0, d};
    @(posedge clk_i);
    while (ack !== 1'h1) @(posedge clk_i);
    q = rdat[7:0];
    cyc <= 1'h0;
    we <= 1'h0;
  endtask
  task automatic chk(input logic [7:0] idx, exp, input string what);
    wb(1'h0, idx, 8'h00);
    check(q, exp, what);
  endtask
  task automatic pulse(input logic [5:0] k);
    @(posedge clk_i);
    kick <= k;
    @(posedge clk_i);
    kick <= 6'h00;
  endtask
  // waits for a run level, bounded by eight ticks
  task automatic wait_run(input logic v);
    int n;
    n = 0;
    while (run !== v && n < 8 * DIV) begin
      @(posedge clk_i);
      n++;
    end
    check({7'h0, run}, {7'h0, v}, "run");
  endtask
  // zero means a temperature edge, else a source pulse
  task automatic act(input logic [5:0] k);
    if (k == 6'h00) begin
      temp <= 1'h0;
      repeat (DIV) @(posedge clk_i);
      temp <= 1'h1;
    end else begin
      pulse(k);
    end
  endtask
  task automatic t_reset;
    chk(8'hc0, 8'h00, "flags");
    chk(8'hc1, 8'hff, "mask");
    chk(8'hff, 8'h00, "unmapped");
    for (int m = 0; m < 4; m++) begin
      mode <= m[1:0];
      temp <= m[0];
      repeat (DIV) @(posedge clk_i);
      wb(1'h0, 8'hd9, 8'h00);
      check(q & 8'hf0, {1'h0, m[0], m[1:0], 4'h0}, "status");
    end
    mode <= 2'h0;
    temp <= 1'h1;
  endtask
  // one source enabled at a time, all six active
  task automatic t_mask;
    logic [7:0] b;
    for (int k = 0; k < 6; k++) begin
      b = (k == 5) ? 8'h80 : 8'h02 << k;
      wb(1'h1, 8'hc1, ~b);
      pulse(6'h3f);
      repeat (2 * DIV) @(posedge clk_i);
      chk(8'hd9, 8'h42, "pending");
      chk(8'hc0, b, "flags");
      chk(8'hc0, 8'h00, "cleared");
      chk(8'hd9, 8'h40, "no pending");
    end
  endtask
  // masks of watchdog ignored in debug and normal
  task automatic t_always;
    wb(1'h1, 8'hc1, 8'hff);
    for (int m = 1; m < 4; m += 2) begin
      mode <= m[1:0];
      pulse(6'h20);
      repeat (2 * DIV) @(posedge clk_i);
      wb(1'h0, 8'hc0, 8'h00);
      check(q & 8'h80, 8'h80, "watchdog");
    end
    mode <= 2'h0;
  endtask
  // stale flag kept over sleep; only new activity wakes
  task automatic t_sleep(input logic [7:0] cmd, msk,
    input logic [5:0] s, k, input logic [7:0] exp);
    wb(1'h1, 8'hc1, msk);
    wb(1'h0, 8'hc0, 8'h00);
    act(s);
    repeat (2 * DIV) @(posedge clk_i);
    wb(1'h1, 8'he0, cmd);
    wait_run(1'h0);
    repeat (3 * DIV) @(posedge clk_i);
    check({7'h0, run}, 8'h00, "asleep");
    act(k);
    wait_run(1'h1);
    chk(8'hc0, exp, "wake flags");
  endtask
  // timer wakes twice unaided, then counts in run
  task automatic t_timer;
    logic [7:0] c;
    wb(1'h1, 8'hbc, 8'h03);
    wb(1'h1, 8'hc1, 8'hfe);
    repeat (2) begin
      wb(1'h0, 8'hc0, 8'h00);
      wb(1'h1, 8'he0, 8'h01);
      wait_run(1'h0);
      wait_run(1'h1);
      chk(8'hc0, 8'h01, "timer flag");
    end
    wb(1'h0, 8'hbc, 8'h00);
    c = q;
    repeat (DIV - 3) @(posedge clk_i);
    chk(8'hbc, (c == 8'h01) ? 8'h03 : c - 8'h01, "count");
  endtask
  // pin activity is ignored while the pin is not set up for wakeup
  task automatic t_cfg;
    cfg <= 1'h0;
    wb(1'h1, 8'hc1, 8'hfd);
    pulse(6'h01);
    repeat (2 * DIV) @(posedge clk_i);
    chk(8'hc0, 8'h00, "unconfigured pin");
    cfg <= 1'h1;
  endtask
  // hang guard
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      fail_count++;
      wrap_up;
    end
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    t_reset;
    t_mask;
    t_cfg;
    t_always;
    t_sleep(8'h01, 8'hf9, 6'h01, 6'h02, 8'h06);
    slow <= 1'h1;
    t_sleep(8'h02, 8'hdf, 6'h01, 6'h10, 8'h20);
    t_sleep(8'h04, 8'hbf, 6'h00, 6'h00, 8'h40);
    t_timer;
    wb(1'h1, 8'hc1, 8'h01);
    pulse(6'h3f);
    repeat (2 * DIV) @(posedge clk_i);
    chk(8'hd9, 8'h42, "pending before reset");
    rst_i <= 1'h1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    chk(8'hc1, 8'hff, "mask again");
    wb(1'h1, 8'hc1, 8'h01);
    chk(8'hd9, 8'h40, "pending again");
    chk(8'hc0, 8'h00, "flags again");
    wrap_up;
  end
endmodule
